//--- design/psp_profiler.sv
// Summary of operation
// RQ1: pedal stroke quantized to 64 steps; speed derived from current step.
// RQ2: five programmable step thresholds, defaults 17, 22, 38, 47, 59.
// RQ3: five programmable section speeds, defaults 440, 920, 4000, 5480, 9960 rpm.
// RQ4: speed of highest threshold reached; below first threshold speed is zero.
// RQ5: after-trim setting one applies slow start after thread trimming.
// RQ6: after-stop setting one applies slow start when sewing resumes after stop.
// RQ7: both trigger settings zero: slow start never applied.
// RQ8: selection setting one uses programmed per-stitch speeds, else standard ones.
// RQ9: per-stitch slow-start speeds default 400, 400, 640, 1000, 1680 rpm.
// RQ10: first five stitches run at min of slow-start and pedal speed.
// RQ11: every commanded speed clamped to programmable maximum, default 3000 rpm.
// RQ12: four backtack correction values held, only 0 to 9 accepted.
// RQ13: backtack defaults three for start sides, four for end sides.
// RQ14: register and program-unit sides share one backtack copy, always identical.
// RQ15: counter configuration: condition, up/down, next action, auto clear.
`timescale 1ns/100ps
module psp_profiler (
    // clock, reset, enable
    input  wire logic                           ref_clk,
    input  wire logic                           srst,
    input  wire logic                           ce,
    // register port
    input  wire logic [psp_pkg::AW-1:0]         reg_addr,
    input  wire logic [psp_pkg::DW-1:0]         reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [psp_pkg::DW-1:0]         reg_rdata,
    // pedal and machine events
    input  wire logic [psp_pkg::PEDAL_W-1:0]    pedal_raw,
    input  wire logic                           stitch_pulse,
    input  wire logic                           trim_done,
    input  wire logic                           motor_stopped,
    // program unit backtack port
    input  wire logic                           pu_bt_wr,
    input  wire logic [1:0]                     pu_bt_sel,
    input  wire logic [3:0]                     pu_bt_val,
    output logic      [3:0]                     bt_start_a,
    output logic      [3:0]                     bt_start_b,
    output logic      [3:0]                     bt_end_c,
    output logic      [3:0]                     bt_end_d,
    // counter configuration
    output logic      [1:0]                     cnt_condition,
    output logic                                cnt_down,
    output logic      [1:0]                     cnt_next_action,
    output logic                                cnt_auto_clear,
    // motor command
    output logic      [psp_pkg::SW-1:0]         cmd_speed,
    output logic                                slow_start_active
);

    typedef struct packed {
        logic [psp_pkg::N_SECT-1:0][psp_pkg::STEP_W-1:0] thr;
        logic [psp_pkg::N_SECT-1:0][psp_pkg::SW-1:0]     spd;
        logic [psp_pkg::N_SS-1:0][psp_pkg::SW-1:0]       ss_spd;
        logic [2:0]                                      ss_ctl;
        logic [psp_pkg::SW-1:0]                          max_spd;
        logic [psp_pkg::N_BT-1:0][3:0]                   bt;
        logic [psp_pkg::CNT_W-1:0]                       cnt_cfg;
        logic                                            ss_act;
        logic [2:0]                                      ss_idx;
        logic                                            stop_d;
        logic [psp_pkg::STEP_W-1:0]                      step;
        logic [psp_pkg::SW-1:0]                          cmd;
        logic [psp_pkg::DW-1:0]                          rdata;
    } psp_state_s;

    psp_state_s r;
    psp_state_s next_r;

    function automatic logic [psp_pkg::SW-1:0] psp_min(
        input logic [psp_pkg::SW-1:0] a,
        input logic [psp_pkg::SW-1:0] b
    );
        return (a < b) ? a : b;
    endfunction

    // later sections override earlier ones, so out-of-order thresholds
    // resolve to the highest-numbered section reached; below the first is stop
    function automatic logic [psp_pkg::SW-1:0] psp_pedal_speed(
        input logic [psp_pkg::STEP_W-1:0]                      step,
        input logic [psp_pkg::N_SECT-1:0][psp_pkg::STEP_W-1:0] thr,
        input logic [psp_pkg::N_SECT-1:0][psp_pkg::SW-1:0]     spd
    );
        logic [psp_pkg::SW-1:0] s;
        s = '0;
        for (int i = 0; i < psp_pkg::N_SECT; i++) begin
            if (step >= thr[i]) begin
                s = spd[i];
            end
        end
        if (step < thr[0]) begin
            s = '0;
        end
        return s;
    endfunction

    logic                   arm;
    logic                   ss_enabled;
    logic [psp_pkg::SW-1:0] pedal_spd;
    logic [psp_pkg::SW-1:0] ss_cur;
    logic [psp_pkg::SW-1:0] prof_spd;
    logic [psp_pkg::AW-1:0] rel;

    always_comb begin
        next_r = r;
        rel = '0;
        ss_enabled = r.ss_ctl[psp_pkg::SS_AFTER_TRIM] | r.ss_ctl[psp_pkg::SS_AFTER_STOP];
        arm = (r.ss_ctl[psp_pkg::SS_AFTER_TRIM] & trim_done) // [RQ5]
            | (r.ss_ctl[psp_pkg::SS_AFTER_STOP] & motor_stopped & ~r.stop_d); // [RQ6]

        // speed path works on the registered step, one cycle behind the pedal
        next_r.step = pedal_raw[psp_pkg::PEDAL_W-1:psp_pkg::STEP_LSB]; // [RQ1]
        pedal_spd = psp_pedal_speed(r.step, r.thr, r.spd); // [RQ4]
        ss_cur = r.ss_ctl[psp_pkg::SS_USE_PROG] ? r.ss_spd[r.ss_idx]
                                                : psp_pkg::SS_SPD_RST[r.ss_idx]; // [RQ8]
        prof_spd = r.ss_act ? psp_min(pedal_spd, ss_cur) : pedal_spd; // [RQ10]
        next_r.cmd = psp_min(prof_spd, r.max_spd); // [RQ11]

        // slow-start stitch tracking; a new trigger restarts the profile
        next_r.stop_d = motor_stopped;
        if (!ss_enabled) begin
            next_r.ss_act = 1'b0; // [RQ7]
            next_r.ss_idx = '0;
        end else if (arm) begin
            next_r.ss_act = 1'b1;
            next_r.ss_idx = '0;
        end else if (r.ss_act && stitch_pulse) begin
            if (r.ss_idx == psp_pkg::SS_LAST) begin
                next_r.ss_act = 1'b0; // [RQ10]
                next_r.ss_idx = '0;
            end else begin
                next_r.ss_idx = r.ss_idx + 3'h1;
            end
        end

        // register writes
        if (reg_wr) begin
            if (reg_addr < psp_pkg::A_SPD0) begin
                rel = reg_addr - psp_pkg::A_THR0;
                next_r.thr[rel[2:0]] = reg_wdata[psp_pkg::STEP_W-1:0]; // [RQ2]
            end else if (reg_addr < psp_pkg::A_SS_CTL) begin
                rel = reg_addr - psp_pkg::A_SPD0;
                next_r.spd[rel[2:0]] = reg_wdata[psp_pkg::SW-1:0]; // [RQ3]
            end else if (reg_addr == psp_pkg::A_SS_CTL) begin
                next_r.ss_ctl = reg_wdata[2:0];
            end else if (reg_addr < psp_pkg::A_MAX_SPD) begin
                rel = reg_addr - psp_pkg::A_SS_SPD0;
                next_r.ss_spd[rel[2:0]] = reg_wdata[psp_pkg::SW-1:0]; // [RQ9]
            end else if (reg_addr == psp_pkg::A_MAX_SPD) begin
                next_r.max_spd = reg_wdata[psp_pkg::SW-1:0];
            end else if (reg_addr < psp_pkg::A_CNT_CFG) begin
                rel = reg_addr - psp_pkg::A_BT0;
                if (reg_wdata[3:0] <= psp_pkg::BT_MAX && reg_wdata[15:4] == '0) begin
                    next_r.bt[rel[1:0]] = reg_wdata[3:0]; // [RQ12]
                end
            end else if (reg_addr == psp_pkg::A_CNT_CFG) begin
                next_r.cnt_cfg = reg_wdata[psp_pkg::CNT_W-1:0]; // [RQ15]
            end
        end
        // program unit edits land in the same copy; it wins a same-cycle clash
        if (pu_bt_wr && pu_bt_val <= psp_pkg::BT_MAX) begin
            next_r.bt[pu_bt_sel] = pu_bt_val; // [RQ14]
        end

        // read data lives one cycle only
        next_r.rdata = '0;
        if (reg_rd) begin
            if (reg_addr < psp_pkg::A_SPD0) begin
                rel = reg_addr - psp_pkg::A_THR0;
                next_r.rdata = {10'h000, r.thr[rel[2:0]]};
            end else if (reg_addr < psp_pkg::A_SS_CTL) begin
                rel = reg_addr - psp_pkg::A_SPD0;
                next_r.rdata = {2'h0, r.spd[rel[2:0]]};
            end else if (reg_addr == psp_pkg::A_SS_CTL) begin
                next_r.rdata = {13'h0000, r.ss_ctl};
            end else if (reg_addr < psp_pkg::A_MAX_SPD) begin
                rel = reg_addr - psp_pkg::A_SS_SPD0;
                next_r.rdata = {2'h0, r.ss_spd[rel[2:0]]};
            end else if (reg_addr == psp_pkg::A_MAX_SPD) begin
                next_r.rdata = {2'h0, r.max_spd};
            end else if (reg_addr < psp_pkg::A_CNT_CFG) begin
                rel = reg_addr - psp_pkg::A_BT0;
                next_r.rdata = {12'h000, r.bt[rel[1:0]]}; // [RQ14]
            end else if (reg_addr == psp_pkg::A_CNT_CFG) begin
                next_r.rdata = {10'h000, r.cnt_cfg};
            end else if (reg_addr == psp_pkg::A_STATUS) begin
                next_r.rdata[psp_pkg::ST_STEP_LSB +: psp_pkg::STEP_W] = r.step;
                next_r.rdata[psp_pkg::ST_ACT_BIT] = r.ss_act;
                next_r.rdata[psp_pkg::ST_IDX_LSB +: 3] = r.ss_idx;
            end else if (reg_addr == psp_pkg::A_CMD) begin
                next_r.rdata = {2'h0, r.cmd};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            r.thr <= psp_pkg::THR_RST; // [RQ2]
            r.spd <= psp_pkg::SPD_RST; // [RQ3]
            r.ss_spd <= psp_pkg::SS_SPD_RST; // [RQ9]
            r.ss_ctl <= psp_pkg::SS_CTL_RST;
            r.max_spd <= psp_pkg::MAX_SPD_RST; // [RQ11]
            r.bt <= psp_pkg::BT_RST; // [RQ13]
            r.cnt_cfg <= psp_pkg::CNT_CFG_RST;
            r.ss_act <= 1'b0;
            r.ss_idx <= '0;
            r.stop_d <= 1'b0;
            r.step <= '0;
            r.cmd <= '0;
            r.rdata <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign bt_start_a = r.bt[0];
    assign bt_start_b = r.bt[1];
    assign bt_end_c = r.bt[2];
    assign bt_end_d = r.bt[3];
    assign cnt_condition = r.cnt_cfg[psp_pkg::CNT_COND_LSB +: 2];
    assign cnt_down = r.cnt_cfg[psp_pkg::CNT_DOWN_BIT];
    assign cnt_next_action = r.cnt_cfg[psp_pkg::CNT_NEXT_LSB +: 2];
    assign cnt_auto_clear = r.cnt_cfg[psp_pkg::CNT_CLR_BIT];
    assign cmd_speed = r.cmd;
    assign slow_start_active = r.ss_act;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_step_quant: assert property (ce |=> r.step == $past(pedal_raw[11:6])) // [RQ1]
        else $error("pedal step not taken from top six bits");
    a_zero_below: assert property (ce && r.step < r.thr[0] |=> r.cmd == 14'h0000) // [RQ4]
        else $error("speed not zero below first threshold");
    a_speed_clamp: assert property (ce |=> r.cmd <= $past(r.max_spd)) // [RQ11]
        else $error("command speed above limit");
    a_ss_limit: assert property (ce && r.ss_act |=> r.cmd <= $past(ss_cur)) // [RQ10]
        else $error("slow-start stitch speed exceeded");
    a_ss_off: assert property (ce && !ss_enabled |=> !r.ss_act) // [RQ7]
        else $error("slow start active while disabled");
    a_trim_arm: assert property (ce && trim_done && r.ss_ctl[0] // [RQ5]
            |=> r.ss_act && r.ss_idx == 3'h0)
        else $error("trim did not start slow start");
    a_stop_arm: assert property (ce && ss_enabled && r.ss_ctl[1] && motor_stopped // [RQ6]
            && !r.stop_d |=> r.ss_act && r.ss_idx == 3'h0)
        else $error("stop did not start slow start");
    a_ss_end: assert property (ce && ss_enabled && !arm && r.ss_act && r.ss_idx == 3'h4 // [RQ10]
            && stitch_pulse |=> !r.ss_act)
        else $error("slow start lasted past fifth stitch");
    a_bt_range: assert property (r.bt[0] <= 4'h9 && r.bt[1] <= 4'h9 // [RQ12]
            && r.bt[2] <= 4'h9 && r.bt[3] <= 4'h9)
        else $error("backtack value out of range");
    a_pu_sync: assert property (ce && pu_bt_wr && pu_bt_val <= 4'h9 // [RQ14]
            |=> r.bt[$past(pu_bt_sel)] == $past(pu_bt_val))
        else $error("program unit edit not reflected");
    a_rd_single: assert property (!(ce && reg_rd) |=> ##0 (!$past(ce) || reg_rdata == 16'h0000))
        else $error("read data outside its cycle");

    // register side
    a_ce_freeze: assert property (!ce |=> r == $past(r))
        else $error("state moved while clock enable low");
    a_thr_wr: assert property (ce && reg_wr && reg_addr == psp_pkg::A_THR0 // [RQ2]
            |=> r.thr[0] == $past(reg_wdata[5:0]))
        else $error("threshold write lost");
    a_spd_wr: assert property (ce && reg_wr && reg_addr == psp_pkg::A_SPD0 // [RQ3]
            |=> r.spd[0] == $past(reg_wdata[13:0]))
        else $error("section speed write lost");
    a_max_wr: assert property (ce && reg_wr && reg_addr == psp_pkg::A_MAX_SPD // [RQ11]
            |=> r.max_spd == $past(reg_wdata[13:0]))
        else $error("speed limit write lost");
    a_cnt_out: assert property (ce && reg_wr && reg_addr == psp_pkg::A_CNT_CFG // [RQ15]
            |=> {cnt_auto_clear, cnt_next_action, cnt_down, cnt_condition}
                == $past(reg_wdata[5:0]))
        else $error("counter configuration not on its outputs");
    a_top_speed: assert property (ce && !r.ss_act && r.step >= r.thr[4] // [RQ4]
            && r.step >= r.thr[0] |=> r.cmd == psp_min($past(r.spd[4]), $past(r.max_spd)))
        else $error("top section speed not commanded");

    // backtack store
    a_bt_bus_wr: assert property (ce && reg_wr && reg_addr == psp_pkg::A_BT0 // [RQ12]
            && reg_wdata <= 16'h0009 && !pu_bt_wr |=> r.bt[0] == $past(reg_wdata[3:0]))
        else $error("valid backtack write lost");
    a_bt_refuse: assert property (ce && reg_wr && reg_wdata > 16'h0009 && !pu_bt_wr // [RQ12]
            |=> r.bt == $past(r.bt))
        else $error("out of range backtack write taken");
    a_pu_refuse: assert property (ce && pu_bt_wr && pu_bt_val > 4'h9 && !reg_wr // [RQ12]
            |=> r.bt == $past(r.bt))
        else $error("out of range program unit value taken");
    a_rd_bt: assert property (ce && reg_rd && reg_addr == psp_pkg::A_BT0 // [RQ14]
            |=> reg_rdata == {12'h000, $past(bt_start_a)})
        else $error("backtack read differs from program unit copy");

    // slow-start stitch count
    a_ss_idx_max: assert property (r.ss_idx <= 3'h4) // [RQ10]
        else $error("stitch index past fifth stitch");
    a_ss_idle: assert property (!r.ss_act |-> r.ss_idx == 3'h0) // [RQ10]
        else $error("stitch index kept while idle");
    a_ss_step: assert property (ce && ss_enabled && !arm && r.ss_act && stitch_pulse // [RQ10]
            && r.ss_idx < 3'h4 |=> r.ss_act && r.ss_idx == $past(r.ss_idx) + 3'h1)
        else $error("stitch did not advance slow start");

    c_trim_profile: cover property (ce && trim_done ##1 r.ss_act [*3]);
    c_stop_profile: cover property (ce && r.ss_ctl[1] && motor_stopped && !r.stop_d
        ##1 r.ss_act);
    c_clamped: cover property (ce && r.ss_act == 1'b0 && pedal_spd > r.max_spd);
    c_pu_edit: cover property (ce && pu_bt_wr ##[1:4] ce && reg_rd && reg_addr == 5'h14);
    c_full_pedal: cover property (ce && r.step == 6'h3F);

endmodule

//--- inc/psp_pkg.sv
package psp_pkg;

    // widths
    localparam int AW = 5;
    localparam int DW = 16;
    localparam int SW = 14;
    localparam int PEDAL_W = 12;
    localparam int STEP_W = 6;
    localparam int STEP_LSB = PEDAL_W - STEP_W;
    localparam int N_SECT = 5;
    localparam int N_SS = 5;
    localparam int N_BT = 4;
    localparam int CNT_W = 6;

    // register map (word addresses on the plain port)
    localparam logic [AW-1:0] A_THR0 = 5'h00;
    localparam logic [AW-1:0] A_SPD0 = 5'h05;
    localparam logic [AW-1:0] A_SS_CTL = 5'h0A;
    localparam logic [AW-1:0] A_SS_SPD0 = 5'h0B;
    localparam logic [AW-1:0] A_MAX_SPD = 5'h10;
    localparam logic [AW-1:0] A_BT0 = 5'h11;
    localparam logic [AW-1:0] A_CNT_CFG = 5'h15;
    localparam logic [AW-1:0] A_STATUS = 5'h16;
    localparam logic [AW-1:0] A_CMD = 5'h17;

    // slow-start control fields
    localparam int SS_AFTER_TRIM = 0;
    localparam int SS_AFTER_STOP = 1;
    localparam int SS_USE_PROG = 2;

    // counter configuration fields
    localparam int CNT_COND_LSB = 0;
    localparam int CNT_DOWN_BIT = 2;
    localparam int CNT_NEXT_LSB = 3;
    localparam int CNT_CLR_BIT = 5;

    // status fields
    localparam int ST_STEP_LSB = 0;
    localparam int ST_ACT_BIT = 8;
    localparam int ST_IDX_LSB = 12;

    // reset values, entry 0 is the first section or stitch
    localparam logic [N_SECT-1:0][STEP_W-1:0] THR_RST =
        {6'h3B, 6'h2F, 6'h26, 6'h16, 6'h11};
    localparam logic [N_SECT-1:0][SW-1:0] SPD_RST =
        {14'h26E8, 14'h1568, 14'h0FA0, 14'h0398, 14'h01B8};
    localparam logic [N_SS-1:0][SW-1:0] SS_SPD_RST =
        {14'h0690, 14'h03E8, 14'h0280, 14'h0190, 14'h0190};
    localparam logic [SW-1:0] MAX_SPD_RST = 14'h0BB8;
    localparam logic [N_BT-1:0][3:0] BT_RST = {4'h4, 4'h4, 4'h3, 4'h3};
    localparam logic [3:0] BT_MAX = 4'h9;
    localparam logic [2:0] SS_CTL_RST = 3'h0;
    localparam logic [CNT_W-1:0] CNT_CFG_RST = 6'h00;
    localparam logic [2:0] SS_LAST = 3'h4;

endpackage

//--- sim/psp_far_model.sv
`timescale 1ns/100ps
module psp_far_model (
    // clock
    input  wire logic                        ref_clk,
    // pedal sensor and machine events
    output logic      [psp_pkg::PEDAL_W-1:0] pedal_raw,
    output logic                             stitch_pulse,
    output logic                             trim_done,
    output logic                             motor_stopped,
    // program unit backtack port
    output logic                             pu_bt_wr,
    output logic      [1:0]                  pu_bt_sel,
    output logic      [3:0]                  pu_bt_val
);
    initial begin
        pedal_raw = '0;
        stitch_pulse = 1'b0;
        trim_done = 1'b0;
        motor_stopped = 1'b0;
        pu_bt_wr = 1'b0;
        pu_bt_sel = 2'h0;
        pu_bt_val = 4'h0;
    end
    // low bits held at a fixed junk pattern 6'h2A: only the top six may matter
    task automatic set_step(input logic [5:0] s);
        @(posedge ref_clk);
        pedal_raw <= {s, 6'h2A};
    endtask
    task automatic stitch();
        @(posedge ref_clk);
        stitch_pulse <= 1'b1;
        @(posedge ref_clk);
        stitch_pulse <= 1'b0;
    endtask
    task automatic trim();
        @(posedge ref_clk);
        trim_done <= 1'b1;
        @(posedge ref_clk);
        trim_done <= 1'b0;
    endtask
    task automatic stop_go();
        @(posedge ref_clk);
        motor_stopped <= 1'b1;
        @(posedge ref_clk);
        motor_stopped <= 1'b0;
    endtask
    // data lines scrambled once the strobe drops
    task automatic pu_write(input logic [1:0] sel, input logic [3:0] val);
        @(posedge ref_clk);
        pu_bt_wr <= 1'b1;
        pu_bt_sel <= sel;
        pu_bt_val <= val;
        @(posedge ref_clk);
        pu_bt_wr <= 1'b0;
        pu_bt_sel <= ~sel;
        pu_bt_val <= ~val;
    endtask
endmodule

//--- sim/pedal_speed_profiler_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module pedal_speed_profiler_tb;
    logic                        ref_clk = 1'b0;
    logic                        srst = 1'b1;
    logic [psp_pkg::AW-1:0]      reg_addr = '0;
    logic [psp_pkg::DW-1:0]      reg_wdata = '0, reg_rdata, d;
    logic                        reg_wr = 1'b0, reg_rd = 1'b0, pu_bt_wr;
    logic                        ce = 1'b1;
    logic [psp_pkg::PEDAL_W-1:0] pedal_raw;
    logic                        stitch_pulse, trim_done, motor_stopped;
    logic [1:0]                  pu_bt_sel, cnt_condition, cnt_next_action;
    logic [3:0]                  pu_bt_val, bt_start_a, bt_start_b, bt_end_c, bt_end_d;
    logic                        cnt_down, cnt_auto_clear, slow_start_active;
    logic [psp_pkg::SW-1:0]      cmd_speed;
    logic [4:0][13:0]            prog = {14'h1770, 14'h1388, 14'h012C, 14'h00C8, 14'h0064};
    logic [5:0]                  steps [12] = '{0, 16, 17, 21, 22, 37, 38, 46, 47, 58, 59, 63};
    int                          n_errors = 0, comparisons = 0;

    always #20 ref_clk = ~ref_clk;

    psp_far_model far (.ref_clk(ref_clk), .pedal_raw(pedal_raw), .stitch_pulse(stitch_pulse),
        .trim_done(trim_done), .motor_stopped(motor_stopped), .pu_bt_wr(pu_bt_wr),
        .pu_bt_sel(pu_bt_sel), .pu_bt_val(pu_bt_val));
    psp_profiler uut (.ref_clk(ref_clk), .srst(srst), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pedal_raw(pedal_raw), .stitch_pulse(stitch_pulse), .trim_done(trim_done),
        .motor_stopped(motor_stopped), .pu_bt_wr(pu_bt_wr), .pu_bt_sel(pu_bt_sel),
        .pu_bt_val(pu_bt_val), .bt_start_a(bt_start_a), .bt_start_b(bt_start_b),
        .bt_end_c(bt_end_c), .bt_end_d(bt_end_d), .cnt_condition(cnt_condition),
        .cnt_down(cnt_down), .cnt_next_action(cnt_next_action),
        .cnt_auto_clear(cnt_auto_clear), .cmd_speed(cmd_speed),
        .slow_start_active(slow_start_active));

    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    function automatic logic [13:0] exp_spd(input logic [5:0] s);
        logic [13:0] r;
        r = '0;
        for (int i = 0; i < 5; i++) if (s >= psp_pkg::THR_RST[i]) r = psp_pkg::SPD_RST[i];
        return r;
    endfunction
    // walks all five slow stitches, then the one that hands back to the pedal
    task automatic ss_walk(input logic [4:0][13:0] tbl, input logic [13:0] ped);
        for (int k = 0; k < 5; k++) begin
            if (k > 0) far.stitch();
            settle();
            `CHK(slow_start_active, 1'b1)
            `CHK(cmd_speed, (tbl[k] < ped) ? tbl[k] : ped)
        end
        far.stitch();
        settle();
        `CHK(slow_start_active, 1'b0)
        `CHK(cmd_speed, ped)
    endtask
    task automatic finish_test();
        if (n_errors == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #(40 * 6000);
        n_errors++;
        finish_test();
    end

    initial begin
        repeat (10) @(posedge ref_clk);
        srst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rd(psp_pkg::A_THR0 + 5'(i), d);
            `CHK(d, 16'(psp_pkg::THR_RST[i]))
            rd(psp_pkg::A_SPD0 + 5'(i), d);
            `CHK(d, 16'(psp_pkg::SPD_RST[i]))
            rd(psp_pkg::A_SS_SPD0 + 5'(i), d);
            `CHK(d, 16'(psp_pkg::SS_SPD_RST[i]))
        end
        for (int i = 0; i < 4; i++) begin
            rd(psp_pkg::A_BT0 + 5'(i), d);
            `CHK(d, 16'(psp_pkg::BT_RST[i]))
        end
        rd(psp_pkg::A_MAX_SPD, d);
        `CHK(d, 16'h0BB8)
        rd(5'h18, d);
        `CHK(d, 16'h0000)
        far.set_step(6'h3F);
        settle();
        `CHK(cmd_speed, 14'h0BB8)
        wr(psp_pkg::A_MAX_SPD, 16'h3FFF);
        foreach (steps[j]) begin
            far.set_step(steps[j]);
            settle();
            `CHK(cmd_speed, exp_spd(steps[j]))
        end
        wr(psp_pkg::A_SS_CTL, 16'h0001);
        far.trim();
        ss_walk(psp_pkg::SS_SPD_RST, 14'h26E8);
        for (int i = 0; i < 5; i++) wr(psp_pkg::A_SS_SPD0 + 5'(i), 16'(prog[i]));
        wr(psp_pkg::A_SS_CTL, 16'h0006);
        far.set_step(6'h16);
        far.trim();
        settle();
        `CHK(slow_start_active, 1'b0)
        far.stop_go();
        ss_walk(prog, 14'h0398);
        wr(psp_pkg::A_SS_CTL, 16'h0000);
        far.trim();
        far.stop_go();
        settle();
        `CHK(slow_start_active, 1'b0)
        `CHK(cmd_speed, 14'h0398)
        wr(psp_pkg::A_BT0, 16'h0009);
        wr(psp_pkg::A_BT0 + 5'h1, 16'h000A);
        settle();
        `CHK(bt_start_a, 4'h9)
        `CHK(bt_start_b, 4'h3)
        far.pu_write(2'h3, 4'h7);
        far.pu_write(2'h2, 4'hC);
        rd(psp_pkg::A_BT0 + 5'h3, d);
        `CHK(d, 16'h0007)
        `CHK(bt_end_d, 4'h7)
        `CHK(bt_end_c, 4'h4)
        wr(psp_pkg::A_CNT_CFG, 16'h0029);
        rd(psp_pkg::A_CNT_CFG, d);
        `CHK(d, 16'h0029)
        `CHK({cnt_auto_clear, cnt_next_action, cnt_down, cnt_condition}, 6'h29)
        wr(psp_pkg::A_SPD0, 16'h01F4);
        wr(psp_pkg::A_THR0 + 5'h1, 16'h0017);
        settle();
        `CHK(cmd_speed, 14'h01F4)
        wr(psp_pkg::A_THR0, 16'h0017);
        settle();
        `CHK(cmd_speed, 14'h0000)
        @(posedge ref_clk);
        ce <= 1'b0;
        far.set_step(6'h3F);
        settle();
        `CHK(cmd_speed, 14'h0000)
        @(posedge ref_clk);
        ce <= 1'b1;
        settle();
        `CHK(cmd_speed, 14'h26E8)
        rd(psp_pkg::A_CMD, d);
        `CHK(d, 16'h26E8)
        rd(psp_pkg::A_STATUS, d);
        `CHK(d, 16'h003F)
        finish_test();
    end
endmodule
